// file: src/hdlc_tx_defines.vh
`ifndef HDLC_TX_DEFINES_VH
`define HDLC_TX_DEFINES_VH

// Register addresses (byte addresses on the local bus)
`define ADDR_TX_LINK_CONFIG 8'h94
`define ADDR_TX_FIFO_DATA 8'h96
`define ADDR_LINK_PORT_STATUS 8'h98
`define ADDR_LINK_HANDSHAKE_CMD 8'h9a
`define ADDR_LINK_VECTOR_MASK 8'h9c

// Reset values
`define CFG_RESET 16'h0000
`define STATUS_RESET 16'h2000
`define MASK_RESET 8'h00

// tx_link_config fields
`define CFG_MSG_END_STROBE_POLARITY 10
`define CFG_TX_REQUEST_POLARITY 9
`define CFG_DMA 8
`define CFG_INV 3
`define CFG_CRCOFF 2
`define CFG_SF 1
`define CFG_XON 0
`define CFG_WMASK 16'h070f

// link_handshake_cmd fields
`define HND_RMC 8
`define HND_ABORT 6
`define HND_TX_PORT_RESET 5
`define HND_XHF 2
`define HND_XME 0

// link_port_status fields
`define ST_XFW 13
`define ST_RBC_LO 8
`define ST_STAT_LO 0

// link_vector_mask fields
`define MSK_ALL_SENT_MASK 5
`define MSK_XDU 4
`define MSK_XPR 3
`define MSK_RPF 2
`define MSK_RME 1
`define MSK_WMASK 8'h3e

// Receive status codes
`define RX_ST_VALID 5'h00
`define RX_ST_OVFL 5'h01
`define RX_ST_ABORT 5'h02
`define RX_ST_NOCT 5'h03
`define RX_ST_CRC 5'h04
`define RX_ST_OFF 5'h05

// FIFO geometry: two pages of 16 words (32 bytes)
`define PAGE_WORDS 5'h10
`define WADDR_W 5

// HDLC constants
`define FLAG_BYTE 8'h7e
`define ABORT_BYTE 8'hff
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8408
`define CRC_XOR 16'hffff
`define ONES_STUFF 3'h5

`endif

// file: src/tx_page_ram.v
`timescale 1ns/100ps
// ==========================================
// Two-page transmit word store, registered read
module tx_page_ram (
    // Clock
    input wire clk,
    // Write port
    input wire wr_en,
    input wire [4:0] wr_addr,
    input wire [15:0] wr_data,
    input wire [1:0] wr_be,
    // Read port
    input wire [4:0] rd_addr,
    output reg [15:0] rd_data
);
    reg [15:0] mem [0:31];

    always @(posedge clk) begin
        if (wr_en && wr_be[0]) begin
            mem[wr_addr][7:0] <= wr_data[7:0];
        end
        if (wr_en && wr_be[1]) begin
            mem[wr_addr][15:8] <= wr_data[15:8];
        end
        rd_data <= mem[rd_addr];
    end
endmodule // tx_page_ram

// file: src/cbit_path_hdlc_controller.v
`timescale 1ns/100ps
`include "hdlc_tx_defines.vh"

// What this block does
// - Message-end strobe is active low when its polarity bit is 0, else high.
// - DMA request output is active low when its polarity bit is 0, else high.
// - DMA enable bit set makes the device request data via the DMA request.
// - Inversion bit set flips every transmitted bit toward the framer.
// - CRC is appended when CRC-off bit is 0, omitted when 1.
// - Shared-flag bit set lets one flag close a frame and open the next.
// - Transmitter works only while the transmitter-on bit is 1.
// - Transmit FIFO is two 32-byte pages; host sees one of 16 words.
// - Each FIFO word is sent from bit 0 up to bit 15.
// - Status bit 13 shows FIFO writable; status resets to 2000 hex.
// - Five-bit receive byte count, cleared by the page release command.
// - Byte count zero with pool-full or message-end means 32 bytes.
// - Receive status codes: good, overflow, abort, not octet, CRC, off.
// - Receiver-off status is given at the first flag after disabling.
// - Receive command with any transmit command drops the transmit commands.
// - Host releases a receive page by writing the release bit after reading.
// - Abort bit aborts the frame being transmitted.
// - Transmitter reset beats other transmit commands, keeps configuration.
// - Frame command without end sends an unfinished frame; needed over 32 bytes.
// - Frame command with end sends rest, CRC if enabled, then closing flag.
// - Mask bits 5..1 suppress their vectors when 1, allow when 0.
// - DMA request asserts while the DMA and transmitter-on bits are 1 and the transmit FIFO has free space.
module cbit_path_hdlc_controller (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Local register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire [1:0] reg_be,
    output reg [15:0] reg_rdata,
    // DMA pins
    input wire dma_msg_end_strobe,
    output reg tx_dma_request,
    // Serial bit toward the transmit framer
    input wire tx_bit_req,
    output reg tx_bit,
    // Receive side status from the receive controller
    input wire rx_page_ready,
    input wire [4:0] rx_byte_count_in,
    input wire [4:0] rx_status_in,
    output reg rx_page_release,
    // Interrupt vector pulses
    output reg vec_all_sent,
    output reg vec_tx_underrun,
    output reg vec_tx_pool_ready,
    output reg vec_rx_pool_full,
    output reg vec_rx_msg_end,
    input wire rx_pool_full_evt,
    input wire rx_msg_end_evt
);
    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_DATA = 5'b00010;
    localparam [4:0] S_CRC = 5'b00100;
    localparam [4:0] S_FLAG = 5'b01000;
    localparam [4:0] S_ABRT = 5'b10000;

    // ==========================================
    // Synchronised pins
    reg dma_msg_end_strobe_s1_q, dma_msg_end_strobe_s2_q;
    reg req_s1_q, req_s2_q, req_s3_q;
    always @(posedge clk) begin
        dma_msg_end_strobe_s1_q <= dma_msg_end_strobe;
        dma_msg_end_strobe_s2_q <= dma_msg_end_strobe_s1_q;
        req_s1_q <= tx_bit_req;
        req_s2_q <= req_s1_q;
        req_s3_q <= req_s2_q;
    end

    // ==========================================
    // Registers
    reg [15:0] cfg_q;
    reg [7:0] mask_q;
    reg [4:0] rbc_q;
    reg [4:0] stat_q;
    wire dma_msg_end_strobe_act = dma_msg_end_strobe_s2_q ^ ~cfg_q[`CFG_MSG_END_STROBE_POLARITY];
    wire wr_cfg = reg_wr && reg_addr == `ADDR_TX_LINK_CONFIG;
    wire wr_fifo = reg_wr && reg_addr == `ADDR_TX_FIFO_DATA;
    wire wr_hnd = reg_wr && reg_addr == `ADDR_LINK_HANDSHAKE_CMD;
    wire wr_msk = reg_wr && reg_addr == `ADDR_LINK_VECTOR_MASK;
    wire cmd_rmc = wr_hnd && reg_wdata[`HND_RMC];
    wire tx_cmds_ok = wr_hnd && !reg_wdata[`HND_RMC];
    wire cmd_tx_port_reset = tx_cmds_ok && reg_wdata[`HND_TX_PORT_RESET];
    wire cmd_abort = tx_cmds_ok && !reg_wdata[`HND_TX_PORT_RESET] && reg_wdata[`HND_ABORT];
    // Frame command; end flag alone is ignored
    wire cmd_xhf = tx_cmds_ok && !reg_wdata[`HND_TX_PORT_RESET] && reg_wdata[`HND_XHF];
    wire cmd_xme = reg_wdata[`HND_XME];

    always @(posedge clk) begin
        if (!rstn) begin
            cfg_q <= `CFG_RESET;
            mask_q <= `MASK_RESET;
            rbc_q <= 5'h00;
            stat_q <= `RX_ST_VALID;
            rx_page_release <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_q <= reg_wdata & `CFG_WMASK;
            end
            if (wr_msk) begin
                mask_q <= reg_wdata[7:0] & `MSK_WMASK;
            end
            rx_page_release <= cmd_rmc;
            // Count and status come from the receive side; 0 with a vector means 32
            if (rx_page_ready) begin
                rbc_q <= rx_byte_count_in;
                stat_q <= rx_status_in;
            end else if (cmd_rmc) begin
                rbc_q <= 5'h00;
            end
        end
    end

    // ==========================================
    // Paged transmit FIFO: 32 words, byte counted
    reg [5:0] wbyte_q;   // host write pointer, in bytes
    reg [5:0] rbyte_q;   // serializer read pointer, in bytes
    reg [5:0] commit_q;  // bytes released for sending
    reg [5:0] wstart_q;  // first byte of the page being filled
    reg end_pend_q;
    wire [5:0] fill = wbyte_q - rbyte_q;
    wire [5:0] page_fill = wbyte_q - wstart_q;
    // Room in the host-visible page; writes are taken only while transmitter is on
    wire room = page_fill < 6'h20 && fill < 6'h3f;
    wire can_write = cfg_q[`CFG_XON] && room;
    wire byte_wr = reg_be != 2'b11;
    wire [15:0] ram_q;
    wire [4:0] ram_raddr = rbyte_q[5:1];
    wire fifo_we = wr_fifo && can_write;
    wire [15:0] fifo_wd = byte_wr && wbyte_q[0] ? {reg_wdata[7:0], 8'h00} : reg_wdata;
    wire [1:0] fifo_be = byte_wr ? (wbyte_q[0] ? 2'b10 : 2'b01) : 2'b11;

    tx_page_ram u_ram (
        .clk(clk),
        .wr_en(fifo_we),
        .wr_addr(wbyte_q[5:1]),
        .wr_data(fifo_wd),
        .wr_be(fifo_be),
        .rd_addr(ram_raddr),
        .rd_data(ram_q)
    );

    // ==========================================
    // Serializer
    reg [4:0] st_q;
    reg [15:0] crc_q;
    reg [7:0] sh_q;
    reg [3:0] bcnt_q;
    reg [2:0] ones_q;
    reg [3:0] ccnt_q;
    reg open_q;
    wire bit_tick = req_s2_q ^ req_s3_q;

    function [15:0] crc_step;
        input [15:0] c;
        input b;
        begin
            crc_step = c[0] ^ b ? (c >> 1) ^ `CRC_POLY : c >> 1;
        end
    endfunction

    wire [15:0] crc_out = crc_q ^ `CRC_XOR;
    wire stuff_now = ones_q == `ONES_STUFF;
    wire cur_bit = rbyte_q[0] ? ram_q[8 + bcnt_q[2:0]] : ram_q[bcnt_q[2:0]];
    wire have_byte = rbyte_q != commit_q;

    always @(posedge clk) begin
        if (!rstn || cmd_tx_port_reset || !cfg_q[`CFG_XON]) begin
            st_q <= S_IDLE;
            wbyte_q <= 6'h00;
            rbyte_q <= 6'h00;
            commit_q <= 6'h00;
            wstart_q <= 6'h00;
            end_pend_q <= 1'b0;
            crc_q <= `CRC_INIT;
            sh_q <= `FLAG_BYTE;
            bcnt_q <= 4'h0;
            ones_q <= 3'h0;
            ccnt_q <= 4'h0;
            open_q <= 1'b0;
            tx_bit <= 1'b0;
            vec_all_sent <= 1'b0;
            vec_tx_underrun <= 1'b0;
        end else begin
            vec_all_sent <= 1'b0;
            vec_tx_underrun <= 1'b0;
            if (fifo_we) begin
                wbyte_q <= wbyte_q + (byte_wr ? 6'h01 : 6'h02);
            end
            if (cmd_xhf || (cfg_q[`CFG_DMA] && fifo_we && dma_msg_end_strobe_act)) begin
                commit_q <= fifo_we ? wbyte_q + (byte_wr ? 6'h01 : 6'h02) : wbyte_q;
                wstart_q <= fifo_we ? wbyte_q + (byte_wr ? 6'h01 : 6'h02) : wbyte_q;
                end_pend_q <= cfg_q[`CFG_DMA] ? 1'b1 : cmd_xme;
            end
            if (cmd_abort && st_q != S_IDLE) begin
                st_q <= S_ABRT;
                ccnt_q <= 4'h0;
                rbyte_q <= commit_q;
                end_pend_q <= 1'b0;
            end else if (bit_tick) begin
                case (st_q)
                    S_IDLE: begin
                        tx_bit <= sh_q[bcnt_q[2:0]] ^ cfg_q[`CFG_INV];
                        bcnt_q <= {1'b0, bcnt_q[2:0] + 3'h1};
                        if (bcnt_q[2:0] == 3'h7 && have_byte) begin
                            st_q <= S_DATA;
                            crc_q <= `CRC_INIT;
                            ones_q <= 3'h0;
                            open_q <= 1'b1;
                        end
                    end
                    S_DATA: begin
                        if (stuff_now) begin
                            tx_bit <= cfg_q[`CFG_INV];
                            ones_q <= 3'h0;
                        end else begin
                            tx_bit <= cur_bit ^ cfg_q[`CFG_INV];
                            crc_q <= crc_step(crc_q, cur_bit);
                            ones_q <= cur_bit ? ones_q + 3'h1 : 3'h0;
                            bcnt_q <= {1'b0, bcnt_q[2:0] + 3'h1};
                            if (bcnt_q[2:0] == 3'h7) begin
                                rbyte_q <= rbyte_q + 6'h01;
                                if (rbyte_q + 6'h01 == commit_q) begin
                                    if (end_pend_q) begin
                                        st_q <= cfg_q[`CFG_CRCOFF] ? S_FLAG : S_CRC;
                                        ccnt_q <= 4'h0;
                                    end else if (commit_q == wbyte_q) begin
                                        st_q <= S_ABRT;
                                        ccnt_q <= 4'h0;
                                        vec_tx_underrun <= !mask_q[`MSK_XDU];
                                    end
                                end
                            end
                        end
                    end
                    S_CRC: begin
                        if (stuff_now) begin
                            tx_bit <= cfg_q[`CFG_INV];
                            ones_q <= 3'h0;
                        end else begin
                            tx_bit <= crc_out[ccnt_q] ^ cfg_q[`CFG_INV];
                            ones_q <= crc_out[ccnt_q] ? ones_q + 3'h1 : 3'h0;
                            ccnt_q <= ccnt_q + 4'h1;
                            if (ccnt_q == 4'hf) begin
                                st_q <= S_FLAG;
                                bcnt_q <= 4'h0;
                            end
                        end
                    end
                    S_FLAG: begin
                        tx_bit <= sh_q[bcnt_q[2:0]] ^ cfg_q[`CFG_INV];
                        bcnt_q <= {1'b0, bcnt_q[2:0] + 3'h1};
                        if (bcnt_q[2:0] == 3'h7) begin
                            end_pend_q <= 1'b0;
                            open_q <= 1'b0;
                            vec_all_sent <= !have_byte && !mask_q[`MSK_ALL_SENT_MASK];
                            // Shared flag lets the next frame start right away
                            if (have_byte && cfg_q[`CFG_SF]) begin
                                st_q <= S_DATA;
                                crc_q <= `CRC_INIT;
                                ones_q <= 3'h0;
                            end else begin
                                st_q <= S_IDLE;
                            end
                        end
                    end
                    default: begin
                        tx_bit <= ~cfg_q[`CFG_INV];
                        ccnt_q <= ccnt_q + 4'h1;
                        if (ccnt_q == 4'h7) begin
                            st_q <= S_IDLE;
                            bcnt_q <= 4'h0;
                            open_q <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Status, DMA request and vector outputs
    reg xfw_prev_q;
    always @(posedge clk) begin
        if (!rstn) begin
            tx_dma_request <= 1'b1;
            xfw_prev_q <= 1'b1;
            vec_tx_pool_ready <= 1'b0;
            vec_rx_pool_full <= 1'b0;
            vec_rx_msg_end <= 1'b0;
        end else begin
            // Request while DMA and transmitter are on and room remains
            tx_dma_request <= (cfg_q[`CFG_DMA] && can_write) ~^ cfg_q[`CFG_TX_REQUEST_POLARITY];
            xfw_prev_q <= room;
            vec_tx_pool_ready <= room && !xfw_prev_q && !mask_q[`MSK_XPR];
            vec_rx_pool_full <= rx_pool_full_evt && !mask_q[`MSK_RPF];
            vec_rx_msg_end <= rx_msg_end_evt && !mask_q[`MSK_RME];
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == `ADDR_TX_LINK_CONFIG) begin
                reg_rdata <= cfg_q;
            end else if (reg_addr == `ADDR_LINK_PORT_STATUS) begin
                reg_rdata <= {2'b00, xfw_prev_q, rbc_q, 3'b000, stat_q};
            end else if (reg_addr == `ADDR_LINK_VECTOR_MASK) begin
                reg_rdata <= {8'h00, mask_q};
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end
endmodule // cbit_path_hdlc_controller

// file: verif/hdlc_link_sva.sv
`timescale 1ns/100ps
`include "hdlc_tx_defines.vh"
module hdlc_link_sva (
    // Clock and reset
    input logic clk,
    input logic rstn,
    // Register port
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_addr,
    input logic [15:0] reg_wdata,
    input logic [15:0] reg_rdata,
    // Receive side and DMA
    input logic tx_dma_request,
    input logic rx_page_ready,
    input logic [4:0] rx_byte_count_in,
    input logic rx_page_release,
    // Vectors and events
    input logic vec_all_sent,
    input logic vec_rx_pool_full,
    input logic vec_rx_msg_end,
    input logic rx_pool_full_evt
);
    // ====================
    // Shadow copies of host-visible state
    logic [15:0] cfg_q;
    logic [7:0] msk_q;
    logic [4:0] rbc_q;
    wire rel = reg_wr && reg_addr == `ADDR_LINK_HANDSHAKE_CMD && reg_wdata[`HND_RMC];
    wire rd_cfg = reg_rd && reg_addr == `ADDR_TX_LINK_CONFIG;
    wire rd_msk = reg_rd && reg_addr == `ADDR_LINK_VECTOR_MASK;
    wire rd_st = reg_rd && reg_addr == `ADDR_LINK_PORT_STATUS;
    wire rd_bad = reg_rd && !(reg_addr inside {8'h94, 8'h96, 8'h98, 8'h9a, 8'h9c});
    always @(posedge clk) begin
        if (!rstn) begin
            cfg_q <= `CFG_RESET;
            msk_q <= `MASK_RESET;
            rbc_q <= 5'h00;
        end else begin
            if (reg_wr && reg_addr == `ADDR_TX_LINK_CONFIG)
                cfg_q <= reg_wdata & `CFG_WMASK;
            if (reg_wr && reg_addr == `ADDR_LINK_VECTOR_MASK)
                msk_q <= reg_wdata[7:0] & `MSK_WMASK;
            if (rx_page_ready)
                rbc_q <= rx_byte_count_in;
            else if (rel)
                rbc_q <= 5'h00;
        end
    end
    // ====================
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_cfg_rd;
        $past(rd_cfg) |-> reg_rdata == cfg_q;
    endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
    property p_msk_rd;
        $past(rd_msk) |-> reg_rdata == {8'h00, msk_q};
    endproperty
    a_msk_rd: assert property (p_msk_rd) else $error("mask readback wrong");
    property p_bad_rd;
        $past(rd_bad) |-> reg_rdata == 16'h0000;
    endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not zero");
    property p_st_rd;
        $past(rd_st) |-> reg_rdata[15:14] == 2'b00 && reg_rdata[12:8] == rbc_q;
    endproperty
    a_st_rd: assert property (p_st_rd) else $error("byte count wrong");
    property p_rel;
        rel |=> rx_page_release;
    endproperty
    a_rel: assert property (p_rel) else $error("page release missing");
    property p_rel_src;
        rx_page_release |-> $past(rel);
    endproperty
    a_rel_src: assert property (p_rel_src) else $error("page release unasked");
    property p_dma_off;
        (!cfg_q[`CFG_DMA] && $stable(cfg_q))[*3] |-> tx_dma_request == !cfg_q[`CFG_TX_REQUEST_POLARITY];
    endproperty
    a_dma_off: assert property (p_dma_off) else $error("request active while off");
    property p_dma_on;
        $rose(cfg_q[`CFG_DMA]) && cfg_q[`CFG_XON] |-> ##[1:4]
            tx_dma_request == cfg_q[`CFG_TX_REQUEST_POLARITY];
    endproperty
    a_dma_on: assert property (p_dma_on) else $error("no request on enable");
    property p_rpf_msk;
        vec_rx_pool_full |-> !msk_q[`MSK_RPF];
    endproperty
    a_rpf_msk: assert property (p_rpf_msk) else $error("masked pool vector");
    property p_rme_msk;
        vec_rx_msg_end |-> !msk_q[`MSK_RME];
    endproperty
    a_rme_msk: assert property (p_rme_msk) else $error("masked end vector");
    property p_rpf_on;
        rx_pool_full_evt && !msk_q[`MSK_RPF] |-> ##[1:2] vec_rx_pool_full;
    endproperty
    a_rpf_on: assert property (p_rpf_on) else $error("pool vector lost");
    c_rel: cover property (rx_page_release);
    c_all_sent_mask: cover property (vec_all_sent);
    c_dma: cover property (cfg_q[`CFG_DMA] && tx_dma_request == cfg_q[`CFG_TX_REQUEST_POLARITY]);
endmodule // hdlc_link_sva
bind cbit_path_hdlc_controller hdlc_link_sva i_hdlc_link_sva (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_dma_request(tx_dma_request),
    .rx_page_ready(rx_page_ready), .rx_byte_count_in(rx_byte_count_in),
    .rx_page_release(rx_page_release), .vec_all_sent(vec_all_sent),
    .vec_rx_pool_full(vec_rx_pool_full), .vec_rx_msg_end(vec_rx_msg_end),
    .rx_pool_full_evt(rx_pool_full_evt)
);

// file: verif/link_sink.sv
`timescale 1ns/100ps
module link_sink (
    // Clock and reset
    input logic clk,
    input logic rstn,
    // Control
    input logic en,
    // Serial link
    input logic tx_bit,
    output logic tx_bit_req,
    output logic [63:0] hist
);
    logic [2:0] div_q;
    // Request toggles stand still while disabled; oldest bit ends at the low end
    always @(posedge clk) begin
        if (!rstn) begin
            div_q <= 3'h0;
            tx_bit_req <= 1'b0;
            hist <= 64'h0;
        end else if (en) begin
            div_q <= div_q + 3'h1;
            if (div_q == 3'h7) begin
                hist <= {tx_bit, hist[63:1]};
                tx_bit_req <= ~tx_bit_req;
            end
        end
    end
endmodule // link_sink

// file: verif/tb_top.sv
`timescale 1ns/100ps
`include "hdlc_tx_defines.vh"
module tb_top;
    // ====================
    // Signals
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [1:0] reg_be = 2'h3;
    logic strobe = 1'b1;
    logic sink_en = 1'b0;
    logic rx_page_ready = 1'b0;
    logic [4:0] rx_cnt = 5'h00;
    logic [4:0] rx_st = 5'h00;
    logic rpf_evt = 1'b0;
    logic rme_evt = 1'b0;
    logic [15:0] reg_rdata, v, cf;
    logic tx_dma_request, tx_bit, tx_bit_req, rx_page_release, got;
    logic v_all_sent_mask, v_xdu, v_xpr, v_rpf, v_rme;
    logic [63:0] hist;
    logic [23:0] pat24 = 24'h0;
    logic [31:0] pat32 = 32'h0;
    int num_errors = 0;
    int n_checks = 0;
    int c24 = 0, c32 = 0, c_all_sent_mask = 0, c_rpf = 0, c_rme = 0, c_xpr = 0, b24, b32, b1, b2;
    // Rows: write flag, address, write data, expected read-back
    logic [40:0] regs [8] = '{{1'b0, 8'h94, 16'h0000, 16'h0000},
        {1'b0, 8'h9c, 16'h0000, 16'h0000}, {1'b1, 8'h94, 16'hffff, 16'h070f},
        {1'b1, 8'h9c, 16'h00ff, 16'h003e}, {1'b1, 8'h9c, 16'h0000, 16'h0000},
        {1'b0, 8'h90, 16'h0000, 16'h0000}, {1'b1, 8'h94, 16'h0001, 16'h0001},
        {1'b0, 8'h98, 16'h0000, 16'h2000}};
    // Rows: configuration, message end given by the DMA strobe
    logic [16:0] frames [5] = '{{16'h0001, 1'b0}, {16'h0009, 1'b0}, {16'h0007, 1'b0},
        {16'h0301, 1'b1}, {16'h0505, 1'b1}};
    cbit_path_hdlc_controller i_cbit_path_hdlc_controller (
        .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_rdata(reg_rdata),
        .dma_msg_end_strobe(strobe), .tx_dma_request(tx_dma_request),
        .tx_bit_req(tx_bit_req), .tx_bit(tx_bit), .rx_page_ready(rx_page_ready),
        .rx_byte_count_in(rx_cnt), .rx_status_in(rx_st), .rx_page_release(rx_page_release),
        .vec_all_sent(v_all_sent_mask), .vec_tx_underrun(v_xdu), .vec_tx_pool_ready(v_xpr),
        .vec_rx_pool_full(v_rpf), .vec_rx_msg_end(v_rme), .rx_pool_full_evt(rpf_evt),
        .rx_msg_end_evt(rme_evt));
    link_sink i_link_sink (.clk(clk), .rstn(rstn), .en(sink_en), .tx_bit(tx_bit),
        .tx_bit_req(tx_bit_req), .hist(hist));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        c24 <= c24 + int'(hist[63:40] == pat24);
        c32 <= c32 + int'(hist[63:32] == pat32);
        c_all_sent_mask <= c_all_sent_mask + int'(v_all_sent_mask);
        c_rpf <= c_rpf + int'(v_rpf);
        c_rme <= c_rme + int'(v_rme);
        c_xpr <= c_xpr + int'(v_xpr);
    end
    // ====================
    // Tasks
    task tick;
        @(posedge clk);
        #2;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
        reg_addr = a;
        reg_wdata = d;
        reg_be = be;
        reg_wr = 1'b1;
        tick;
        reg_wr = 1'b0;
        tick;
    endtask
    task rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        tick;
        d = reg_rdata;
        reg_rd = 1'b0;
        tick;
    endtask
    task wait_all_sent_mask(output logic ok);
        int b;
        b = c_all_sent_mask;
        ok = 1'b0;
        for (int k = 0; k < 3000 && !ok; k++) begin
            tick;
            ok = (c_all_sent_mask != b);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ====================
    // Sequence
    initial begin
        repeat (6) @(posedge clk);
        #2;
        rstn = 1'b1;
        tick;
        foreach (regs[i]) begin
            if (regs[i][40])
                wr(regs[i][39:32], regs[i][31:16], 2'h3);
            rd(regs[i][39:32], v);
            chk(v, regs[i][15:0]);
        end
        $display("register table done");
        for (int i = 0; i < 16; i++) begin
            rd(8'h98, v);
            chk(v & 16'h2000, 16'h2000);
            wr(8'h96, 16'h1234, 2'h3);
        end
        rd(8'h98, v);
        chk(v & 16'h2000, 16'h0000);
        b1 = c_xpr;
        wr(8'h9a, 16'h0020, 2'h3);
        rd(8'h98, v);
        chk(v & 16'h2000, 16'h2000);
        chk(16'(c_xpr != b1), 16'h0001);
        rd(8'h94, v);
        chk(v, 16'h0001);
        $display("fifo fill done");
        for (int i = 0; i < 6; i++) begin
            rx_cnt = 5'(i * 3);
            rx_st = 5'(i);
            rx_page_ready = 1'b1;
            tick;
            rx_page_ready = 1'b0;
            tick;
            rd(8'h98, v);
            chk(v & 16'h1f1f, {3'h0, rx_cnt, 3'h0, rx_st});
        end
        wr(8'h96, 16'h0055, 2'h1);
        sink_en = 1'b1;
        wr(8'h9a, 16'h0105, 2'h3);
        wait_all_sent_mask(got);
        chk(16'(got), 16'h0000);
        rd(8'h98, v);
        chk(v & 16'h1f00, 16'h0000);
        sink_en = 1'b0;
        $display("receive status done");
        for (int m = 0; m < 2; m++) begin
            wr(8'h9c, m ? 16'h003e : 16'h0000, 2'h3);
            b1 = c_rpf;
            b2 = c_rme;
            rpf_evt = 1'b1;
            rme_evt = 1'b1;
            tick;
            rpf_evt = 1'b0;
            rme_evt = 1'b0;
            repeat (3) tick;
            chk(16'(c_rpf != b1), 16'(m == 0));
            chk(16'(c_rme != b2), 16'(m == 0));
        end
        wr(8'h9c, 16'h0000, 2'h3);
        $display("vector mask done");
        foreach (frames[i]) begin
            cf = frames[i][16:1];
            pat24 = 24'h12347e ^ {24{cf[`CFG_INV]}};
            pat32 = 32'h7e12347e ^ {32{cf[`CFG_INV]}};
            strobe = ~cf[`CFG_MSG_END_STROBE_POLARITY];
            wr(8'h9a, 16'h0020, 2'h3);
            wr(8'h94, cf, 2'h3);
            b24 = c24;
            b32 = c32;
            sink_en = 1'b1;
            if (frames[i][0]) begin
                repeat (4) tick;
                chk(16'(tx_dma_request), 16'(cf[`CFG_TX_REQUEST_POLARITY]));
                strobe = cf[`CFG_MSG_END_STROBE_POLARITY];
                repeat (3) tick;
                wr(8'h96, 16'h1234, 2'h3);
                strobe = ~cf[`CFG_MSG_END_STROBE_POLARITY];
            end else begin
                wr(8'h96, 16'h1234, 2'h3);
                wr(8'h9a, 16'h0005, 2'h3);
            end
            wait_all_sent_mask(got);
            if (!got) begin
                num_errors++;
                finish_test;
            end
            repeat (40) tick;
            sink_en = 1'b0;
            chk(16'(c24 != b24), 16'h0001);
            chk(16'(c32 != b32), 16'(cf[`CFG_CRCOFF]));
        end
        $display("frames done");
        rstn = 1'b0;
        repeat (2) tick;
        rstn = 1'b1;
        tick;
        chk(16'(tx_dma_request), 16'h0001);
        rd(8'h98, v);
        chk(v, 16'h2000);
        rd(8'h94, v);
        chk(v, 16'h0000);
        $display("second reset done");
        finish_test;
    end
endmodule // tb_top
